// file: verilog/ttrop_pkg.sv
// package: constants, types and the behaviour list for the triggered tag read output port
// Behaviour
// - power-up drives all data lines zero
// - trigger with tag present starts access
// - read data on lines, indicators lit
// - tag leaves: off-delay then clear lines
// - retrigger during off-delay clears, restarts cycle
// - parity set and cleared with data
// - strobe 3 ms after data, off with delay
// - trigger without tag is no-tag error
// - tag leaving mid-access is an error
// - error sets all ones, flashes red code
// - error starts off-delay timer immediately
// - parity zero on all-ones error pattern
// - strobe and error 3 ms after data
// - low error output doubles as run
// - new trigger with tag present clears every output line
// - indicators hold until next trigger
`default_nettype none
package ttrop_pkg;
  // ==================================================================
  // sizes and timing
  localparam int          DATA_W       = 16;
  localparam int          CODE_W       = 4;
  localparam int          CLK_HZ       = 100_000_000;
  localparam int          MS_CYC       = CLK_HZ / 1000;
  localparam int          STROBE_MS    = 3;
  localparam int          MS_W         = 16;
  localparam int          MS_CNT_W     = 17;
  localparam logic [15:0] OFFDLY_MS_DEF = 16'h0064;
  localparam int          FLASH_MS     = 250;
  localparam logic [15:0] ALL_ONES     = 16'hFFFF;
  localparam logic [15:0] ALL_ZEROS    = 16'h0000;
  localparam logic [3:0]  ERR_NO_TAG   = 4'h1;
  localparam logic [3:0]  ERR_LOST_TAG = 4'h2;

  // ==================================================================
  // wishbone register map (byte addresses)
  localparam logic [7:0]  ADR_CTRL     = 8'h00;
  localparam logic [7:0]  ADR_STATUS   = 8'h04;
  localparam logic [7:0]  ADR_DATA     = 8'h08;

  typedef enum logic [2:0] {
    TTROP_IDLE, TTROP_ACCESS, TTROP_SETTLE, TTROP_HOLD, TTROP_OFFDLY
  } ttrop_state_e;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              parity;
    logic              strobe;
    logic              error;
  } ttrop_out_s;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              done;
  } ttrop_rd_s;
endpackage
`default_nettype wire

// file: verilog/ttrop_sync.sv
// two-flop synchroniser for one pin level
`default_nettype none
module ttrop_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_ff;
  logic q_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= 1'b0;
      q_ff    <= 1'b0;
    end else begin
      meta_ff <= d_i;
      q_ff    <= meta_ff;
    end
  end
  assign q_o = q_ff;
endmodule // ttrop_sync
`default_nettype wire

// file: verilog/ttrop_ms_timer.sv
// millisecond timer: prescaler plus millisecond down counter
`default_nettype none
module ttrop_ms_timer
  import ttrop_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYC
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  start_i,
  input  wire logic [MS_W-1:0]       ms_i,
  output logic                       done_o
);
  logic [MS_CNT_W-1:0] pre_ff;
  logic [MS_CNT_W-1:0] nxt_pre;
  logic [MS_W-1:0]     ms_ff;
  logic [MS_W-1:0]     nxt_ms;
  logic                run_ff;
  logic                nxt_run;
  logic                done_ff;
  logic                nxt_done;

  always_comb begin
    nxt_pre  = pre_ff;
    nxt_ms   = ms_ff;
    nxt_run  = run_ff;
    nxt_done = 1'b0;
    if (start_i) begin
      nxt_pre = MS_CNT_W'(MS_CYCLES - 1);
      nxt_ms  = ms_i;
      nxt_run = 1'b1;
    end else if (run_ff) begin
      if (pre_ff != '0) begin
        nxt_pre = pre_ff - 1'b1;
      end else if (ms_ff <= 16'h0001) begin
        nxt_run  = 1'b0;
        nxt_done = 1'b1;
      end else begin
        nxt_pre = MS_CNT_W'(MS_CYCLES - 1);
        nxt_ms  = ms_ff - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_ff  <= '0;
      ms_ff   <= '0;
      run_ff  <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      pre_ff  <= nxt_pre;
      ms_ff   <= nxt_ms;
      run_ff  <= nxt_run;
      done_ff <= nxt_done;
    end
  end
  assign done_o = done_ff;
endmodule // ttrop_ms_timer
`default_nettype wire

// file: verilog/ttrop_top.sv
// triggered tag read output sequencer with wishbone control registers
//
// Local design decisions: the register offsets and register access over Wishbone.
`default_nettype none
module ttrop_top
  import ttrop_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYC
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // pins
  input  wire logic                  read_trigger_i,
  input  wire logic                  tag_present_i,
  // tag reader front end
  output logic                       tag_access_start_o,
  input  wire ttrop_pkg::ttrop_rd_s  tag_rd_i,
  // host outputs
  output ttrop_pkg::ttrop_out_s      host_out_o,
  output logic      [DATA_W-1:0]     indicator_green_o,
  output logic      [CODE_W-1:0]     indicator_red_o
);
  logic trig_s;
  logic tag_s;

  // ==================================================================
  // pin synchronisers
  ttrop_sync u_sync_trig (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (read_trigger_i),
    .q_o   (trig_s)
  );
  ttrop_sync u_sync_tag (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (tag_present_i),
    .q_o   (tag_s)
  );

  // ==================================================================
  // state
  ttrop_state_e      state_ff, nxt_state;
  ttrop_out_s        out_ff, nxt_out;
  logic              trig_d_ff, nxt_trig_d;
  logic              err_ff, nxt_err;
  logic [CODE_W-1:0] code_ff, nxt_code;
  logic [DATA_W-1:0] green_ff, nxt_green;
  logic              start_ff, nxt_start;
  logic              tmr_start;
  logic [MS_W-1:0]   tmr_ms;
  logic              tmr_done;
  logic              trig_rise;
  logic [MS_W-1:0]   offdly_ms_ff, nxt_offdly_ms;
  logic [7:0]        flash_ff, nxt_flash;
  logic [MS_CNT_W-1:0] fpre_ff, nxt_fpre;
  logic              flash_on_ff, nxt_flash_on;
  logic [CODE_W-1:0] red_ff, nxt_red;
  logic [15:0]       nerr_ff, nxt_nerr;
  logic              ack_ff, nxt_ack;
  logic [31:0]       rdat_ff, nxt_rdat;

  assign trig_rise = trig_s & ~trig_d_ff;

  ttrop_ms_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) u_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (tmr_start),
    .ms_i    (tmr_ms),
    .done_o  (tmr_done)
  );

  // ==================================================================
  // output sequencer
  always_comb begin
    nxt_state  = state_ff;
    nxt_out    = out_ff;
    nxt_trig_d = trig_s;
    nxt_err    = err_ff;
    nxt_code   = code_ff;
    nxt_green  = green_ff;
    nxt_start  = 1'b0;
    nxt_nerr   = nerr_ff;
    tmr_start  = 1'b0;
    tmr_ms     = offdly_ms_ff;
    if (trig_rise) begin
      // new trigger wins over any running off-delay
      nxt_out   = '0;
      nxt_green = '0;
      nxt_code  = '0;
      nxt_err   = 1'b0;
      if (tag_s) begin
        nxt_state = TTROP_ACCESS;
        nxt_start = 1'b1;
      end else begin
        nxt_err   = 1'b1;
        nxt_code  = ERR_NO_TAG;
        nxt_nerr  = nerr_ff + 1'b1;
        nxt_out.data   = ALL_ONES;
        nxt_out.parity = ^ALL_ONES;
        nxt_state = TTROP_SETTLE;
        tmr_start = 1'b1;
        tmr_ms    = MS_W'(STROBE_MS);
      end
    end else begin
      case (state_ff)
        TTROP_IDLE: begin
          nxt_out = '0;
        end
        TTROP_ACCESS: begin
          if (!tag_s) begin
            nxt_err   = 1'b1;
            nxt_code  = ERR_LOST_TAG;
            nxt_nerr  = nerr_ff + 1'b1;
            nxt_out.data   = ALL_ONES;
            nxt_out.parity = ^ALL_ONES;
            nxt_state = TTROP_SETTLE;
            tmr_start = 1'b1;
            tmr_ms    = MS_W'(STROBE_MS);
          end else if (tag_rd_i.done) begin
            nxt_out.data   = tag_rd_i.data;
            nxt_out.parity = ^tag_rd_i.data;
            nxt_green = tag_rd_i.data;
            nxt_state = TTROP_SETTLE;
            tmr_start = 1'b1;
            tmr_ms    = MS_W'(STROBE_MS);
          end
        end
        TTROP_SETTLE: begin
          if (tmr_done) begin
            nxt_out.strobe = 1'b1;
            nxt_out.error  = err_ff;
            if (err_ff) begin
              // off-delay counts from the error; 3 ms settle is already part of it
              nxt_state = TTROP_OFFDLY;
              tmr_start = 1'b1;
              tmr_ms    = (offdly_ms_ff > MS_W'(STROBE_MS)) ?
                          offdly_ms_ff - MS_W'(STROBE_MS) : MS_W'(1);
            end else begin
              nxt_state = TTROP_HOLD;
            end
          end
        end
        TTROP_HOLD: begin
          if (!tag_s) begin
            nxt_state = TTROP_OFFDLY;
            tmr_start = 1'b1;
          end
        end
        TTROP_OFFDLY: begin
          if (tmr_done) begin
            nxt_out   = '0;
            nxt_state = TTROP_IDLE;
          end
        end
        default: nxt_state = TTROP_IDLE;
      endcase
    end
  end

  // ==================================================================
  // red indicator flash, half period in ms
  always_comb begin
    nxt_fpre     = fpre_ff;
    nxt_flash    = flash_ff;
    nxt_flash_on = flash_on_ff;
    if (!err_ff) begin
      nxt_fpre     = '0;
      nxt_flash    = '0;
      nxt_flash_on = 1'b0;
    end else if (fpre_ff != '0) begin
      nxt_fpre = fpre_ff - 1'b1;
    end else begin
      nxt_fpre = MS_CNT_W'(MS_CYCLES - 1);
      if (flash_ff == 8'(FLASH_MS - 1)) begin
        nxt_flash    = '0;
        nxt_flash_on = ~flash_on_ff;
      end else begin
        nxt_flash = flash_ff + 1'b1;
      end
    end
    // red lamp is registered so it leaves the block glitch free
    nxt_red = nxt_flash_on ? nxt_code : '0;
  end

  // ==================================================================
  // wishbone slave, one wait state, ack drops after one cycle
  always_comb begin
    nxt_ack       = 1'b0;
    nxt_rdat      = '0;
    nxt_offdly_ms = offdly_ms_ff;
    if (wb_cyc_i && wb_stb_i && !ack_ff) begin
      nxt_ack = 1'b1;
      if (wb_adr_i == ADR_CTRL) begin
        nxt_rdat = {16'h0000, offdly_ms_ff};
        if (wb_we_i && wb_sel_i[0]) begin
          nxt_offdly_ms[7:0] = wb_dat_i[7:0];
        end
        if (wb_we_i && wb_sel_i[1]) begin
          nxt_offdly_ms[15:8] = wb_dat_i[15:8];
        end
      end else if (wb_adr_i == ADR_STATUS) begin
        nxt_rdat = {nerr_ff, 5'h00, 3'(state_ff), code_ff, err_ff,
                    tag_s, trig_s, out_ff.strobe};
      end else if (wb_adr_i == ADR_DATA) begin
        nxt_rdat = {15'h0000, out_ff.parity, out_ff.data};
      end else begin
        nxt_rdat = 32'h0000_0000;
      end
    end
  end

  // ==================================================================
  // sequencer registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff  <= TTROP_IDLE;
      out_ff    <= '0;
      trig_d_ff <= 1'b0;
      err_ff    <= 1'b0;
      code_ff   <= '0;
      green_ff  <= '0;
      start_ff  <= 1'b0;
      nerr_ff   <= '0;
    end else begin
      state_ff  <= nxt_state;
      out_ff    <= nxt_out;
      trig_d_ff <= nxt_trig_d;
      err_ff    <= nxt_err;
      code_ff   <= nxt_code;
      green_ff  <= nxt_green;
      start_ff  <= nxt_start;
      nerr_ff   <= nxt_nerr;
    end
  end

  // ==================================================================
  // flash registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fpre_ff     <= '0;
      flash_ff    <= '0;
      flash_on_ff <= 1'b0;
      red_ff      <= '0;
    end else begin
      fpre_ff     <= nxt_fpre;
      flash_ff    <= nxt_flash;
      flash_on_ff <= nxt_flash_on;
      red_ff      <= nxt_red;
    end
  end

  // ==================================================================
  // wishbone registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff       <= 1'b0;
      rdat_ff      <= '0;
      offdly_ms_ff <= OFFDLY_MS_DEF;
    end else begin
      ack_ff       <= nxt_ack;
      rdat_ff      <= nxt_rdat;
      offdly_ms_ff <= nxt_offdly_ms;
    end
  end

  assign host_out_o         = out_ff;
  assign tag_access_start_o = start_ff;
  assign indicator_green_o  = green_ff;
  assign indicator_red_o    = red_ff;
  assign wb_ack_o           = ack_ff;
  assign wb_dat_o           = rdat_ff;
endmodule // ttrop_top
`default_nettype wire

// file: verif/ttrop_checker.sv
// assertion checker for the triggered tag read output port
`default_nettype none
module ttrop_checker
  import ttrop_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYC
) (
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  read_trigger_i,
  input wire logic                  tag_present_i,
  input wire logic                  tag_access_start_o,
  input wire ttrop_pkg::ttrop_out_s host_out_o,
  input wire logic [DATA_W-1:0]     indicator_green_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // cycles since data left zero; the strobe delay is judged on it
  int age_ff;
  int nxt_age;
  always_comb nxt_age = (host_out_o.data == ALL_ZEROS) ? 0 : age_ff + 1;
  always_ff @(posedge clk_i) age_ff <= rst_i ? 0 : nxt_age;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_reset_clear: assert property ($fell(rst_i) |->
    host_out_o == '0 && indicator_green_o == '0) else $error("reset left outputs set");
  a_parity_xor: assert property (host_out_o.parity == ^host_out_o.data)
    else $error("parity differs from data");
  a_err_ones: assert property (host_out_o.error |-> host_out_o.data == ALL_ONES)
    else $error("error without all ones");
  a_strobe_data: assert property (host_out_o.strobe |-> host_out_o.data != ALL_ZEROS)
    else $error("strobe on empty lines");
  a_strobe_delay: assert property ($rose(host_out_o.strobe) |->
    age_ff >= 3 * MS_CYCLES - 1 && age_ff <= 3 * MS_CYCLES + 4) else $error("strobe delay");
  a_err_strobe: assert property ($rose(host_out_o.error) |-> $rose(host_out_o.strobe))
    else $error("error rose apart from strobe");
  a_trig_clear: assert property ($rose(read_trigger_i) && tag_present_i |->
    ##[1:5] host_out_o == '0) else $error("trigger did not clear");
  a_notag_err: assert property ($rose(read_trigger_i) && !tag_present_i |->
    ##[1:6] host_out_o.data == ALL_ONES) else $error("no-tag error missing");
  a_access_go: assert property ($rose(read_trigger_i) && tag_present_i |->
    ##[2:6] tag_access_start_o) else $error("access not started");
  a_off_clear: assert property ($fell(host_out_o.strobe) |-> host_out_o == '0)
    else $error("strobe fell alone");
  c_read: cover property ($rose(host_out_o.strobe) && !host_out_o.error);
  c_err: cover property ($rose(host_out_o.error));
  c_go: cover property ($rose(tag_access_start_o));
endmodule // ttrop_checker
bind ttrop_top ttrop_checker #(.MS_CYCLES(MS_CYCLES)) chk_u (.clk_i, .rst_i, .read_trigger_i,
  .tag_present_i, .tag_access_start_o, .host_out_o, .indicator_green_o);
`default_nettype wire

// file: verif/ttrop_host_model.sv
// host controller model: held trigger pulse and strobe-qualified capture
`default_nettype none
module ttrop_host_model
  import ttrop_pkg::*;
#(
  parameter int HOLD_CYC = 100,
  parameter int POLL_CYC = 8
) (
  input  wire logic                  clk_i,
  input  wire logic                  req_i,
  input  wire ttrop_pkg::ttrop_out_s host_out_i,
  output logic                       trig_o,
  output logic      [DATA_W-1:0]     cap_o,
  output logic      [DATA_W-1:0]     poll_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // a shorter trigger would be a host fault, so the model never gives one
  int   left = 0;
  int   tick = 0;
  logic stb_q;
  always @(posedge clk_i) begin
    stb_q <= host_out_i.strobe;
    if (req_i) left <= HOLD_CYC;
    else if (left > 0) left <= left - 1;
    trig_o <= req_i || left > 1;
    if (host_out_i.strobe && stb_q === 1'b0) cap_o <= host_out_i.data;
    // a strobe-less host polls from its trigger on, skipping idle and error patterns
    if (req_i) tick <= 1;
    else if (tick > 0) tick <= tick % POLL_CYC + 1;
    if (tick == POLL_CYC && host_out_i.data !== ALL_ZEROS && host_out_i.data !== ALL_ONES)
      poll_o <= host_out_i.data;
  end
endmodule // ttrop_host_model
`default_nettype wire

// file: verif/tb.sv
// self-checking testbench for the triggered tag read output port
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ttrop_pkg::*;
  // ==========
  localparam int MSC = 10;
  localparam int OFF = 5;
  typedef struct packed {logic [15:0] d; logic p;} ttrop_row_s;
  logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic        tag_present_i = 0, req = 0, wb_ack_o, read_trigger_i, tag_access_start_o;
  logic [7:0]  wb_adr_i = '0;
  logic [3:0]  wb_sel_i = 4'hF, indicator_red_o;
  logic [31:0] wb_dat_i = '0, wb_dat_o, q;
  logic [15:0] indicator_green_o, cap, poll;
  ttrop_rd_s   tag_rd_i = '0;
  ttrop_out_s  host_out_o;
  int          n_mismatch = 0, num_checks = 0;
  // rows avoid all ones and all zeros
  ttrop_row_s  rows [4] = '{'{16'h1234, 1'b1}, '{16'h00FF, 1'b0}, '{16'h8001, 1'b0},
                            '{16'hA5A4, 1'b1}};
  ttrop_top #(.MS_CYCLES(MSC)) dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .read_trigger_i, .tag_present_i,
    .tag_access_start_o, .tag_rd_i, .host_out_o, .indicator_green_o, .indicator_red_o);
  ttrop_host_model #(.HOLD_CYC(10 * MSC), .POLL_CYC(MSC)) host_u (.clk_i, .req_i(req),
    .host_out_i(host_out_o), .trig_o(read_trigger_i), .cap_o(cap), .poll_o(poll));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (n = 0; n < 20 && wb_ack_o !== 1'b1; n++) @(posedge clk_i);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    chk(n < 20, "no ack");
  endtask
  task automatic trig(input logic tag);
    while (read_trigger_i === 1'b1) @(posedge clk_i);
    tag_present_i <= tag;
    repeat (4) @(posedge clk_i);
    req <= 1'b1;
    @(posedge clk_i);
    req <= 1'b0;
  endtask
  task automatic read_tag(input logic [15:0] d);
    int n;
    trig(1'b1);
    for (n = 0; n < 20 && tag_access_start_o !== 1'b1; n++) @(posedge clk_i);
    chk(n < 20 && host_out_o === '0 && indicator_green_o === '0, "start");
    tag_rd_i <= '{data: d, done: 1'b1};
    @(posedge clk_i);
    tag_rd_i.done <= 1'b0;
    for (n = 0; n < 60 && host_out_o.strobe !== 1'b1; n++) @(posedge clk_i);
    @(posedge clk_i);
    chk(host_out_o.data === d && indicator_green_o === d && cap === d && poll === d &&
        indicator_red_o === '0, "data");
  endtask
  task automatic leave(input logic [15:0] d);
    int n;
    tag_present_i <= 1'b0;
    for (n = 0; n < 400 && host_out_o.data !== ALL_ZEROS; n++) @(posedge clk_i);
    chk(n >= OFF * MSC && n <= OFF * MSC + 8, "off-delay");
    chk(host_out_o === '0 && indicator_green_o === d, "clear");
  endtask
  task automatic err_case(input logic lost, input logic [3:0] code);
    int n;
    trig(lost);
    for (n = 0; lost && n < 20 && tag_access_start_o !== 1'b1; n++) @(posedge clk_i);
    tag_present_i <= 1'b0;
    for (n = 0; n < 80 && host_out_o.error !== 1'b1; n++) @(posedge clk_i);
    chk(host_out_o === {ALL_ONES, 3'b011} && indicator_green_o === '0,
        "error lines");
    wb(1'b0, ADR_STATUS, '0);
    chk(q[7:3] === {code, 1'b1}, "error code");
    for (n = 0; n < 80 && host_out_o.data !== ALL_ZEROS; n++) @(posedge clk_i);
    chk(n >= MSC && n <= 2 * MSC + 2 && host_out_o === '0, "error clear");
    for (n = 0; n < 300 * MSC && indicator_red_o !== code; n++) @(posedge clk_i);
    chk(n >= (FLASH_MS - 10) * MSC && n <= FLASH_MS * MSC, "red flash");
  endtask
  initial begin
    repeat (1000 * MSC) @(posedge clk_i);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(host_out_o === '0, "reset");
    wb(1'b0, ADR_CTRL, '0);
    chk(q[15:0] === OFFDLY_MS_DEF, "ctrl default");
    wb(1'b1, ADR_CTRL, OFF);
    wb(1'b0, 8'h0C, '0);
    chk(q === '0, "unmapped");
    foreach (rows[i]) begin
      read_tag(rows[i].d);
      chk(host_out_o.parity === rows[i].p, "parity");
      leave(rows[i].d);
    end
    // retrigger while the off-delay still runs; a long delay outlasts the trigger hold
    wb(1'b1, ADR_CTRL, 4 * OFF);
    read_tag(16'h3C3C);
    tag_present_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk(host_out_o.data === 16'h3C3C, "off-delay hold");
    read_tag(16'h0F0F);
    wb(1'b1, ADR_CTRL, OFF);
    leave(16'h0F0F);
    err_case(1'b0, ERR_NO_TAG);
    err_case(1'b1, ERR_LOST_TAG);
    read_tag(16'h7E81);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(host_out_o === '0 && indicator_green_o === '0, "mid-run reset");
    give_verdict();
  end
endmodule // tb
`default_nettype wire
